// *** shared/stdb_regs.vh ***
// register map, field positions and counts for the standby controller
`ifndef STDB_REGS_VH
`define STDB_REGS_VH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define STDB_OFS_CTRL      4'h0
`define STDB_OFS_STATUS    4'h4
`define STDB_OFS_PLATCH    4'h8
`define STDB_OFS_PDIR      4'hc

// ----------------------------------------------------------------------------
// control register fields and reset value
// ----------------------------------------------------------------------------
`define STDB_CTRL_STBY_SEL   0
`define STDB_CTRL_OUT_DIS    1
`define STDB_CTRL_WAIT_STOP  2
`define STDB_CTRL_MAIN_EXT   3
`define STDB_CTRL_SUB_EXT    4
`define STDB_CTRL_PORT_XC    5
`define STDB_CTRL_SUB_SYS    6
`define STDB_CTRL_WDT_FSEL   7
`define STDB_CTRL_EXPAND     8
`define STDB_CTRL_W          9
`define STDB_CTRL_RST        9'h000

// ----------------------------------------------------------------------------
// counts
// ----------------------------------------------------------------------------
`define STDB_WDT_W           12
`define STDB_WDT_LOAD        12'hfff
`define STDB_EXT_DIV2_CNT    3'h7
`define STDB_DIV_W           9

`endif

// *** verilog/stdb_div.v ***
// binary prescaler giving one-cycle ticks at divide-by-2^(k+1)
`timescale 1ns/1ps
`default_nettype none
module stdb_div #(
  parameter W = 9
) (
  input  wire         i_ref_clk,
  input  wire         i_rst,
  input  wire         i_tick,
  output wire [W-1:0] o_div_tick
);
  reg [W-1:0] cnt_q;

  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= {W{1'b0}};
    end else if (i_tick) begin
      cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
    end
  end

  // tick k marks the input tick that completes a divide-by-2^(k+1) period
  genvar k;
  generate
    for (k = 0; k < W; k = k + 1) begin : g_tick
      assign o_div_tick[k] = i_tick & (&cnt_q[k:0]);
    end
  endgenerate
endmodule // stdb_div
`default_nettype wire

// *** verilog/stdb_wdt.v ***
// 12-bit watchdog down counter with all-ones preload
`timescale 1ns/1ps
`default_nettype none
module stdb_wdt #(
  parameter W = 12
) (
  input  wire         i_ref_clk,
  input  wire         i_rst,
  input  wire         i_load,
  input  wire         i_tick,
  output wire [W-1:0] o_count,
  output wire         o_msb
);
  reg [W-1:0] cnt_q;

  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= {W{1'b1}};
    end else if (i_load) begin
      cnt_q <= {W{1'b1}};
    end else if (i_tick) begin
      cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
    end
  end

  assign o_count = cnt_q;
  assign o_msb   = cnt_q[W-1];
endmodule // stdb_wdt
`default_nettype wire

// *** verilog/stdb_standby.v ***
// standby controller: wait/stop clock gating, pin retention, register slave
//
// Added by the designer: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "stdb_regs.vh"
module stdb_standby #(
  parameter PW = 32
) (
  input  wire          i_ref_clk,
  input  wire          i_rst,
  // avalon-mm slave
  input  wire [3:0]    i_address,
  input  wire          i_read,
  input  wire          i_write,
  input  wire [31:0]   i_writedata,
  input  wire [3:0]    i_byteenable,
  output reg  [31:0]   o_readdata,
  output wire          o_waitrequest,
  // cpu core side
  input  wire          i_wait_instruction,
  input  wire          i_stop_instruction,
  input  wire          i_irq_accept,
  input  wire          i_bus_busy,
  input  wire          i_enable_strobe_n,
  input  wire [PW-1:0] i_port_out,
  input  wire [PW-1:0] i_port_oe,
  // sub clock pin
  input  wire          i_sub_clk,
  // clock tree and pins
  output wire          o_cpu_clk_en,
  output wire          o_sys_clk_en,
  output wire          o_div_clk_en,
  output wire          o_main_osc_en,
  output wire          o_sub_osc_en,
  output wire          o_subclock_div32_tick,
  output wire          o_wdt_tick,
  output wire [11:0]   o_wdt_count,
  output reg           o_clk_out,
  output reg           o_enable_strobe_n,
  output reg  [PW-1:0] o_port_pins,
  output reg  [PW-1:0] o_port_pins_oe,
  output wire          o_standby
);

  // --------------------------------------------------------------------------
  // states
  // --------------------------------------------------------------------------
  localparam [2:0] ST_RUN   = 3'h0;
  localparam [2:0] ST_WDRN  = 3'h1;
  localparam [2:0] ST_WAIT  = 3'h2;
  localparam [2:0] ST_SDRN  = 3'h3;
  localparam [2:0] ST_STOP  = 3'h4;
  localparam [2:0] ST_STAB  = 3'h5;
  localparam [2:0] ST_EXT   = 3'h6;

  reg  [2:0]                 state_q;
  reg  [2:0]                 state_d;
  reg  [`STDB_CTRL_W-1:0]    ctrl_q;
  reg  [PW-1:0]              latch_q;
  reg  [PW-1:0]              dir_q;
  reg                        force_q;
  reg                        wdt_load;
  reg  [2:0]                 ext_cnt_q;
  reg                        ack_q;
  reg                        sub_s1_q;
  reg                        sub_s2_q;
  reg                        sub_s3_q;

  wire [`STDB_DIV_W-1:0]     mdiv;
  wire [`STDB_DIV_W-1:0]     sdiv;
  wire [`STDB_WDT_W-1:0]     wdt_cnt;
  wire                       wdt_msb;

  wire stby_sel  = ctrl_q[`STDB_CTRL_STBY_SEL];
  wire out_dis   = ctrl_q[`STDB_CTRL_OUT_DIS];
  wire wait_stop = ctrl_q[`STDB_CTRL_WAIT_STOP];
  wire main_ext  = ctrl_q[`STDB_CTRL_MAIN_EXT];
  wire sub_ext   = ctrl_q[`STDB_CTRL_SUB_EXT];
  wire port_xc   = ctrl_q[`STDB_CTRL_PORT_XC];
  wire sub_sys   = ctrl_q[`STDB_CTRL_SUB_SYS];
  wire wdt_fsel  = ctrl_q[`STDB_CTRL_WDT_FSEL];
  wire expand    = ctrl_q[`STDB_CTRL_EXPAND];
  wire sel_ext   = sub_sys ? sub_ext : main_ext;

  // --------------------------------------------------------------------------
  // sub clock pin synchroniser and edge tick
  // --------------------------------------------------------------------------
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      sub_s1_q <= 1'b0;
      sub_s2_q <= 1'b0;
      sub_s3_q <= 1'b0;
    end else begin
      sub_s1_q <= i_sub_clk;
      sub_s2_q <= sub_s1_q;
      sub_s3_q <= sub_s2_q;
    end
  end

  wire sub_tick = sub_s2_q & ~sub_s3_q & port_xc;

  // --------------------------------------------------------------------------
  // clock gating
  // --------------------------------------------------------------------------
  wire in_stop  = (state_q == ST_STOP);
  wire sys_halt = in_stop | ((state_q == ST_WAIT) & wait_stop);
  wire cpu_run  = (state_q == ST_RUN) | (state_q == ST_WDRN) |
                  (state_q == ST_SDRN);

  assign o_cpu_clk_en  = cpu_run;
  assign o_sys_clk_en  = ~sys_halt;
  assign o_div_clk_en  = ~sys_halt;
  // oscillators run except in stop (sub only once port-xc is set); an external input keeps its circuit off
  assign o_main_osc_en = ~in_stop & ~main_ext;
  assign o_sub_osc_en  = ~in_stop & port_xc & ~sub_ext;
  assign o_standby     = ~cpu_run;

  wire sys_tick = (sub_sys ? sub_tick : 1'b1) & ~sys_halt;

  stdb_div #(
    .W (`STDB_DIV_W)
  ) u_sys_div (
    .i_ref_clk  (i_ref_clk),
    .i_rst      (i_rst),
    .i_tick     (sys_tick),
    .o_div_tick (mdiv)
  );

  // separate prescaler so the clock timer tick survives a system clock halt in wait, though not in stop
  stdb_div #(
    .W (`STDB_DIV_W)
  ) u_sub_div (
    .i_ref_clk  (i_ref_clk),
    .i_rst      (i_rst),
    .i_tick     (sub_tick & ~in_stop),
    .o_div_tick (sdiv)
  );

  assign o_subclock_div32_tick = sdiv[4];

  // --------------------------------------------------------------------------
  // watchdog source select and counter
  // --------------------------------------------------------------------------
  wire forced_src = sub_sys ? mdiv[2] : mdiv[4];
  wire normal_src = wdt_fsel ? mdiv[8] : mdiv[4];
  assign o_wdt_tick = force_q ? forced_src : normal_src;

  stdb_wdt #(
    .W (`STDB_WDT_W)
  ) u_wdt (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_load    (wdt_load),
    .i_tick    (o_wdt_tick),
    .o_count   (wdt_cnt),
    .o_msb     (wdt_msb)
  );

  assign o_wdt_count = wdt_cnt;

  // --------------------------------------------------------------------------
  // standby sequencer
  // --------------------------------------------------------------------------
  always @* begin
    state_d  = state_q;
    wdt_load = 1'b0;
    case (state_q)
      ST_RUN: begin
        // one-cycle requests from the core
        if (i_stop_instruction) begin
          state_d = ST_SDRN;
        end else if (i_wait_instruction) begin
          state_d = ST_WDRN;
        end
      end
      ST_WDRN: begin
        if (!i_bus_busy) begin
          state_d = ST_WAIT;
        end
      end
      ST_SDRN: begin
        if (!i_bus_busy) begin
          state_d  = ST_STOP;
          wdt_load = 1'b1;
        end
      end
      ST_WAIT: begin
        if (i_irq_accept) begin
          state_d = ST_RUN;
        end
      end
      ST_STOP: begin
        if (i_irq_accept) begin
          state_d = sel_ext ? ST_EXT : ST_STAB;
        end
      end
      ST_STAB: begin
        if (!wdt_msb) begin
          state_d = ST_RUN;
        end
      end
      ST_EXT: begin
        if (mdiv[0] && ext_cnt_q == `STDB_EXT_DIV2_CNT - 3'h1) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  // reset leaves stop with the cpu clock live at once: the reset driver
  // must hold reset until the oscillator has settled
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // seventh div2 clock after restart ends the external-input wait
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ext_cnt_q <= 3'h0;
    end else if (state_q != ST_EXT) begin
      ext_cnt_q <= 3'h0;
    end else if (mdiv[0]) begin
      ext_cnt_q <= ext_cnt_q + 3'h1;
    end
  end

  // forced source: set at stop entry, dropped once msb falls
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      force_q <= 1'b0;
    end else if (wdt_load) begin
      force_q <= 1'b1;
    end else if (!wdt_msb) begin
      force_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // clock output pin
  // --------------------------------------------------------------------------
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_clk_out <= 1'b0;
    end else if (sys_halt) begin
      o_clk_out <= 1'b0;
    end else if (sys_tick) begin
      o_clk_out <= ~o_clk_out;
    end
  end

  // --------------------------------------------------------------------------
  // bus and port pins in standby
  // --------------------------------------------------------------------------
  // latch output only works in expansion modes with every direction bit set
  wire drive_latch = stby_sel & expand & (&dir_q);
  wire live        = cpu_run;

  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_port_pins       <= {PW{1'b0}};
      o_port_pins_oe    <= {PW{1'b0}};
      o_enable_strobe_n <= 1'b1;
    end else if (live && state_d == state_q) begin
      o_port_pins       <= i_port_out;
      o_port_pins_oe    <= i_port_oe;
      o_enable_strobe_n <= i_enable_strobe_n;
    end else if (live) begin
      // cycle the request is taken and last cycle before the cpu clock stops: strobe high
      o_port_pins       <= i_port_out;
      o_port_pins_oe    <= i_port_oe;
      o_enable_strobe_n <= 1'b1;
    end else begin
      if (drive_latch) begin
        o_port_pins    <= latch_q;
        o_port_pins_oe <= {PW{1'b1}};
      end
      o_enable_strobe_n <= ~(stby_sel & out_dis);
    end
  end

  // --------------------------------------------------------------------------
  // register slave: one wait cycle per access
  // --------------------------------------------------------------------------
  wire req = i_read | i_write;
  assign o_waitrequest = req & ~ack_q;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0]  be;
    integer b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (be[b]) begin
          merge[b*8 +: 8] = wd[b*8 +: 8];
        end
      end
    end
  endfunction

  wire [31:0] ctrl_w = merge({{(32-`STDB_CTRL_W){1'b0}}, ctrl_q},
                             i_writedata, i_byteenable);
  wire        wr_en  = i_write & ack_q;

  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ack_q      <= 1'b0;
      o_readdata <= 32'h0000_0000;
    end else begin
      ack_q <= req & ~ack_q;
      if (i_read && !ack_q) begin
        case (i_address)
          `STDB_OFS_CTRL:   o_readdata <= {23'h000000, ctrl_q};
          `STDB_OFS_STATUS: o_readdata <= {4'h0, wdt_cnt, 11'h000,
                                           force_q, o_standby, state_q};
          `STDB_OFS_PLATCH: o_readdata <= latch_q;
          `STDB_OFS_PDIR:   o_readdata <= dir_q;
          default:          o_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_q  <= `STDB_CTRL_RST;
      latch_q <= {PW{1'b0}};
      dir_q   <= {PW{1'b0}};
    end else if (wr_en) begin
      case (i_address)
        `STDB_OFS_CTRL: begin
          ctrl_q <= ctrl_w[`STDB_CTRL_W-1:0];
          // port-xc bit is cleared only by reset
          ctrl_q[`STDB_CTRL_PORT_XC] <= ctrl_w[`STDB_CTRL_PORT_XC] | port_xc;
        end
        `STDB_OFS_PLATCH: latch_q <= merge(latch_q, i_writedata,
                                           i_byteenable);
        `STDB_OFS_PDIR:   dir_q   <= merge(dir_q, i_writedata,
                                           i_byteenable);
        default: begin
        end
      endcase
    end
  end

endmodule // stdb_standby
`default_nettype wire

// *** sim/stdb_standby_sva.sv ***
// assertion checker for the standby controller ports
`timescale 1ns/1ps
`default_nettype none
module stdb_standby_sva #(
  parameter PW = 32
) (
  input wire logic          i_ref_clk,
  input wire logic          i_rst,
  input wire logic          i_wait_instruction,
  input wire logic          i_stop_instruction,
  input wire logic          i_irq_accept,
  input wire logic          i_bus_busy,
  input wire logic          o_cpu_clk_en,
  input wire logic          o_sys_clk_en,
  input wire logic          o_div_clk_en,
  input wire logic          o_main_osc_en,
  input wire logic [11:0]   o_wdt_count,
  input wire logic          o_clk_out,
  input wire logic [PW-1:0] o_port_pins,
  input wire logic          o_standby
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  logic ext_q;
  logic stop_q;
  // oscillator off while running means external main input
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ext_q  <= 1'b0;
      stop_q <= 1'b0;
    end else begin
      if (!o_standby) ext_q <= !o_main_osc_en;
      stop_q <= o_standby && (stop_q || (!o_main_osc_en && !ext_q));
    end
  end
  req_to_halt_a: assert property ((i_wait_instruction || i_stop_instruction)
    && !o_standby && !i_bus_busy |=> ##1 o_standby) else $error("no halt");
  bus_drain_a: assert property (i_bus_busy && !o_standby |=> !o_standby)
    else $error("halt during bus access");
  stop_load_a: assert property ($fell(o_cpu_clk_en) && $fell(o_main_osc_en)
    |-> o_wdt_count == 12'hfff) else $error("watchdog not preloaded");
  sys_div_gate_a: assert property (!o_sys_clk_en |-> !o_div_clk_en && !o_cpu_clk_en)
    else $error("clock still running");
  clk_out_low_a: assert property (!o_sys_clk_en && $past(!o_sys_clk_en) |-> !o_clk_out)
    else $error("clock output not low");
  wdt_frozen_a: assert property (!o_div_clk_en && $past(!o_div_clk_en)
    |-> $stable(o_wdt_count)) else $error("watchdog counts while halted");
  wait_wake_a: assert property (i_irq_accept && o_standby && o_main_osc_en
    |=> o_cpu_clk_en) else $error("late wake from wait");
  stab_hold_a: assert property ($rose(o_cpu_clk_en) && stop_q
    |-> !o_wdt_count[11]) else $error("cpu clock before watchdog msb clear");
  pins_hold_a: assert property (o_standby && $past(o_standby) && $past(o_standby, 2)
    |-> $stable(o_port_pins)) else $error("pins moved in standby");
  cover property ($fell(o_main_osc_en) && o_standby);
  cover property (stop_q && $rose(o_cpu_clk_en));
  cover property (o_standby && o_sys_clk_en && o_clk_out);
endmodule // stdb_standby_sva
bind stdb_standby stdb_standby_sva #(.PW(PW)) u_sva (
  .i_ref_clk          (i_ref_clk),
  .i_rst              (i_rst),
  .i_wait_instruction (i_wait_instruction),
  .i_stop_instruction (i_stop_instruction),
  .i_irq_accept       (i_irq_accept),
  .i_bus_busy         (i_bus_busy),
  .o_cpu_clk_en       (o_cpu_clk_en),
  .o_sys_clk_en       (o_sys_clk_en),
  .o_div_clk_en       (o_div_clk_en),
  .o_main_osc_en      (o_main_osc_en),
  .o_wdt_count        (o_wdt_count),
  .o_clk_out          (o_clk_out),
  .o_port_pins        (o_port_pins),
  .o_standby          (o_standby)
);
`default_nettype wire

// *** sim/stdb_core_model.sv ***
// cpu core model: standby request pulses, bus activity, port data
`timescale 1ns/1ps
`default_nettype none
module stdb_core_model (
  input  wire logic   i_ref_clk,
  output logic        o_wait_instruction,
  output logic        o_stop_instruction,
  output logic        o_irq_accept,
  output logic        o_bus_busy,
  output logic        o_enable_strobe_n,
  output logic [31:0] o_port_out,
  output logic [31:0] o_port_oe
);
  initial begin
    o_wait_instruction = 1'b0;
    o_stop_instruction = 1'b0;
    o_irq_accept = 1'b0;
    o_bus_busy = 1'b0;
    o_enable_strobe_n = 1'b1;
    o_port_out = 32'h0;
    o_port_oe = 32'h0;
  end
  // port data keeps moving so that retention is visible
  always @(posedge i_ref_clk) begin
    o_port_out <= $urandom;
    o_port_oe <= $urandom;
    o_enable_strobe_n <= ~o_enable_strobe_n;
  end
  // one-cycle pulse: 0 wait, 1 stop, 2 interrupt accepted
  task automatic pulse(input int k);
    @(posedge i_ref_clk);
    o_wait_instruction <= (k == 0);
    o_stop_instruction <= (k == 1);
    o_irq_accept <= (k == 2);
    @(posedge i_ref_clk);
    o_wait_instruction <= 1'b0;
    o_stop_instruction <= 1'b0;
    o_irq_accept <= 1'b0;
  endtask
  task automatic busy(input logic b);
    @(posedge i_ref_clk);
    o_bus_busy <= b;
  endtask
endmodule // stdb_core_model
`default_nettype wire

// *** sim/stdb_standby_tb.sv ***
// self-checking bench for the standby controller
`timescale 1ns/1ps
`default_nettype none
`include "stdb_regs.vh"
module stdb_standby_tb;
  logic        clk;
  logic        rst;
  logic [3:0]  av_addr;
  logic        av_rd;
  logic        av_wr;
  logic [31:0] av_wd;
  logic [31:0] rdata;
  logic [31:0] latch;
  logic [31:0] pins0;
  logic [11:0] wdt0;
  logic [2:0]  sc_cnt;
  logic        co;
  logic [3:0]  av_be;
  logic [31:0] oe0;
  int          num_errors;
  int          checks_done;
  int          n;
  int          t;
  int          tk;
  wire         w_wait, w_stop, w_irq, w_busy, w_estr_n, wreq, cpu_en, sys_en;
  wire         div_en, mosc, sub_tk, clk_out, estr_n;
  wire [31:0]  w_pout, readdata, pins, pins_oe;
  wire [11:0]  wdt;
  wire         sosc, wtk, stby;
  wire [31:0]  w_poe;

  stdb_standby #(.PW(32)) dut (
    .i_ref_clk(clk), .i_rst(rst), .i_address(av_addr), .i_read(av_rd),
    .i_write(av_wr), .i_writedata(av_wd), .i_byteenable(av_be),
    .o_readdata(readdata), .o_waitrequest(wreq),
    .i_wait_instruction(w_wait), .i_stop_instruction(w_stop),
    .i_irq_accept(w_irq), .i_bus_busy(w_busy),
    .i_enable_strobe_n(w_estr_n), .i_port_out(w_pout),
    .i_port_oe(w_poe), .i_sub_clk(sc_cnt[2]),
    .o_cpu_clk_en(cpu_en), .o_sys_clk_en(sys_en), .o_div_clk_en(div_en),
    .o_main_osc_en(mosc), .o_sub_osc_en(sosc),
    .o_subclock_div32_tick(sub_tk),
    .o_wdt_tick(wtk), .o_wdt_count(wdt), .o_clk_out(clk_out),
    .o_enable_strobe_n(estr_n), .o_port_pins(pins),
    .o_port_pins_oe(pins_oe), .o_standby(stby)
  );
  stdb_core_model core (
    .i_ref_clk(clk), .o_wait_instruction(w_wait), .o_stop_instruction(w_stop),
    .o_irq_accept(w_irq), .o_bus_busy(w_busy), .o_enable_strobe_n(w_estr_n),
    .o_port_out(w_pout), .o_port_oe(w_poe)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // sub clock pin at one eighth of the reference
  always @(posedge clk) sc_cnt <= sc_cnt + 3'h1;

  // ------
  // checks and bus access
  // ------
  function automatic int stab_min();
    return (1 << (`STDB_WDT_W - 1)) * 32 - 32;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic print_verdict;
    if (num_errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic bound(input int k, input int lim);
    if (k >= lim) begin
      chk("wait_bound", 0, 1);
      print_verdict();
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    av_addr <= a;
    av_wd <= d;
    av_rd <= !w;
    av_wr <= w;
    // waitrequest and read data are taken at the rising edge only
    do begin
      @(posedge clk);
      k++;
    end while (wreq !== 1'b0 && k < 50);
    bound(k, 50);
    rdata = readdata;
    av_rd <= 1'b0;
    av_wr <= 1'b0;
  endtask
  task automatic wait_cpu(input int lim);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (cpu_en !== 1'b1 && n < lim);
    bound(n, lim);
  endtask
  task automatic cyc(input int c);
    repeat (c) @(negedge clk);
  endtask
  task automatic do_reset;
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
  endtask

  // ------
  // main sequence
  // ------
  initial begin
    av_addr = 4'h0;
    av_be = 4'hf;
    av_rd = 1'b0;
    av_wr = 1'b0;
    av_wd = 32'h0;
    sc_cnt = 3'h0;
    num_errors = 0;
    checks_done = 0;
    void'($urandom(84));
    do_reset();
    bus(0, `STDB_OFS_CTRL, 0);
    chk("ctrl_rst", `STDB_CTRL_RST, rdata);
    bus(1, 4'h1, 32'hffff_ffff);
    bus(0, 4'h1, 0);
    chk("unmapped", 0, rdata);
    // random byte lanes on a control write
    latch = $urandom;
    av_be <= latch[3:0];
    bus(1, `STDB_OFS_CTRL, 32'h0000_0100);
    av_be <= 4'hf;
    bus(0, `STDB_OFS_CTRL, 0);
    chk("ctrl_lanes", {23'h0, latch[1], 8'h00}, rdata);
    // stop with external main input
    bus(1, `STDB_OFS_CTRL, 1 << `STDB_CTRL_MAIN_EXT);
    cyc(1);
    chk("ext_osc", 0, mosc);
    core.pulse(1);
    cyc(3);
    chk("ext_stop", 0, sys_en);
    core.pulse(2);
    wait_cpu(40);
    chk("ext_resume", 1, n >= 12 && n <= 16);
    // plain wait; external select cleared before any later stop
    bus(1, `STDB_OFS_CTRL, 0);
    core.pulse(0);
    cyc(3);
    chk("w0_gate", 4'b0111, {cpu_en, sys_en, div_en, stby});
    chk("w0_estr", 1, estr_n);
    pins0 = pins;
    oe0 = pins_oe;
    co = clk_out;
    t = 0;
    tk = 0;
    repeat (64) begin
      @(negedge clk);
      t += (clk_out !== co);
      tk += (wtk === 1'b1);
      co = clk_out;
    end
    chk("w0_clkout", 64, t);
    chk("w0_wdt_run", 2, tk);
    chk("w0_pins", pins0, pins);
    chk("w0_oe", oe0, pins_oe);
    core.pulse(2);
    cyc(1);
    chk("w0_wake", 2'b10, {cpu_en, stby});
    // wait with system clock stopped, sub oscillator on
    bus(1, `STDB_OFS_CTRL, (1 << `STDB_CTRL_WAIT_STOP) | (1 << `STDB_CTRL_PORT_XC));
    core.pulse(0);
    cyc(3);
    chk("w1_gate", 3'b010, {sys_en, mosc, div_en});
    chk("w1_sosc", 1, sosc);
    chk("w1_clkout", 0, clk_out);
    wdt0 = wdt;
    t = 0;
    tk = 0;
    repeat (600) begin
      @(negedge clk);
      t += (sub_tk === 1'b1);
      tk += (wtk === 1'b1);
    end
    chk("w1_wdt", wdt0, wdt);
    chk("w1_wdt_tick", 0, tk);
    chk("w1_subtick", 1, t >= 2);
    core.pulse(2);
    cyc(1);
    chk("w1_wake", 1, cpu_en);
    // stop during a bus access, latch drive and strobe low
    latch = $urandom;
    bus(1, `STDB_OFS_PLATCH, latch);
    bus(1, `STDB_OFS_PDIR, 32'hffff_ffff);
    bus(1, `STDB_OFS_CTRL, (1 << `STDB_CTRL_STBY_SEL) | (1 << `STDB_CTRL_OUT_DIS)
        | (1 << `STDB_CTRL_EXPAND) | (1 << `STDB_CTRL_PORT_XC));
    core.busy(1);
    core.pulse(1);
    cyc(4);
    chk("drain_busy", 1, cpu_en);
    core.busy(0);
    cyc(4);
    chk("stp_gate", 5'h00, {cpu_en, sys_en, div_en, mosc, sosc});
    chk("stp_wdt", `STDB_WDT_LOAD, wdt);
    chk("stp_pins", latch, pins);
    chk("stp_oe", 32'hffff_ffff, pins_oe);
    chk("stp_estr", 0, estr_n);
    core.pulse(2);
    cyc(1);
    chk("stp_sys", 1, sys_en);
    wait_cpu(70000);
    chk("stab_len", 1, n >= stab_min());
    chk("stab_msb", 0, wdt[11]);
    // stop left by reset
    core.pulse(1);
    cyc(3);
    chk("rst_stop", 0, cpu_en);
    @(posedge clk);
    do_reset();
    cyc(1);
    chk("rst_exit", 2'b11, {cpu_en, sys_en});
    bus(0, `STDB_OFS_CTRL, 0);
    chk("rst_ctrl", `STDB_CTRL_RST, rdata);
    bus(0, `STDB_OFS_STATUS, 0);
    chk("rst_force", 0, rdata[4]);
    print_verdict();
  end
endmodule // stdb_standby_tb
`default_nettype wire
